// ---- core/csb_pkg.sv ----
package csb_pkg;

	// ==========================================================
	// Widths
	localparam int PC_WIDTH   = 16;
	localparam int DATA_WIDTH = 8;

	// ==========================================================
	// Status register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_H = 5;

	localparam logic [DATA_WIDTH-1:0] STATUS_RESET = 8'h00;

	// ==========================================================
	// Program counter steps
	localparam logic [PC_WIDTH-1:0] PC_STEP_NEXT     = 16'h0001;
	localparam logic [PC_WIDTH-1:0] PC_STEP_SKIP_ONE = 16'h0002;
	localparam logic [PC_WIDTH-1:0] PC_STEP_SKIP_TWO = 16'h0003;

	// ==========================================================
	// Cycle counts
	localparam logic [1:0] CYCLES_PLAIN    = 2'h1;
	localparam logic [1:0] CYCLES_BRANCH   = 2'h2;
	localparam logic [1:0] CYCLES_SKIP_ONE = 2'h2;
	localparam logic [1:0] CYCLES_SKIP_TWO = 2'h3;

	// ==========================================================
	// Operations
	typedef enum logic [3:0] {
		OP_COMPARE_SKIP_EQUAL,
		OP_COMPARE_REGISTERS,
		OP_COMPARE_CARRY,
		OP_COMPARE_IMMEDIATE,
		OP_SKIP_REG_LOW,
		OP_SKIP_REG_HIGH,
		OP_SKIP_IO_LOW,
		OP_SKIP_IO_HIGH,
		OP_BRANCH_FLAG_HIGH,
		OP_BRANCH_FLAG_LOW
	} csb_op_type;

	// Immediate operand travels in rrValue; flag select travels in bitSel
	typedef struct packed {
		csb_op_type            op;
		logic [DATA_WIDTH-1:0] rdValue;
		logic [DATA_WIDTH-1:0] rrValue;
		logic [DATA_WIDTH-1:0] ioValue;
		logic [2:0]            bitSel;
		logic [6:0]            offset;
	} csb_request_type;

	typedef struct packed {
		logic [PC_WIDTH-1:0]   pcNext;
		logic [DATA_WIDTH-1:0] statusOut;
		logic                  statusWrite;
		logic                  taken;
	} csb_result_type;

endpackage : csb_pkg

// ---- core/csb_unit.sv ----
module csb_unit
(
	input  wire logic                                ref_clk,
	input  wire logic                                rst_b,
	input  wire logic                                reqValid,
	input  wire csb_pkg::csb_request_type            req,
	input  wire logic [csb_pkg::PC_WIDTH-1:0]        pcIn,
	input  wire logic [csb_pkg::DATA_WIDTH-1:0]      statusIn,
	input  wire logic                                nextIsTwoWord,
	output logic                                     reqReady,
	output logic                                     done,
	output csb_pkg::csb_result_type                  result
);

	// ==========================================================
	// Compare arithmetic
	function automatic logic [csb_pkg::DATA_WIDTH-1:0] compareFlags
	(
		input logic [csb_pkg::DATA_WIDTH-1:0] a,
		input logic [csb_pkg::DATA_WIDTH-1:0] b,
		input logic                           borrowIn,
		input logic                           chainZero,
		input logic [csb_pkg::DATA_WIDTH-1:0] status
	);
		logic [csb_pkg::DATA_WIDTH-1:0] diff;
		logic [csb_pkg::DATA_WIDTH-1:0] flags;
		diff  = a - b - {7'h00, borrowIn};
		flags = status;
		flags[csb_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
		flags[csb_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
		flags[csb_pkg::FLAG_V] = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
		flags[csb_pkg::FLAG_N] = diff[7];
		// Carry form keeps zero only if the earlier byte was zero too
		flags[csb_pkg::FLAG_Z] = (diff == 8'h00) & (chainZero ? status[csb_pkg::FLAG_Z] : 1'b1);
		return flags;
	endfunction : compareFlags

	function automatic logic isSkipOp(input csb_pkg::csb_op_type op);
		return op inside {csb_pkg::OP_COMPARE_SKIP_EQUAL, csb_pkg::OP_SKIP_REG_LOW,
			csb_pkg::OP_SKIP_REG_HIGH, csb_pkg::OP_SKIP_IO_LOW, csb_pkg::OP_SKIP_IO_HIGH};
	endfunction : isSkipOp

	function automatic logic isCompareOp(input csb_pkg::csb_op_type op);
		return op inside {csb_pkg::OP_COMPARE_REGISTERS, csb_pkg::OP_COMPARE_CARRY,
			csb_pkg::OP_COMPARE_IMMEDIATE};
	endfunction : isCompareOp

	// ==========================================================
	// Decode of the incoming request
	typedef enum {ST_IDLE, ST_WAIT} csb_state_type;

	csb_state_type                    state_reg;
	csb_state_type                    state_next;
	logic [1:0]                       count_reg;
	logic [1:0]                       count_next;
	logic                             done_reg;
	logic                             done_next;
	csb_pkg::csb_result_type          result_reg;
	csb_pkg::csb_result_type          result_next;
	csb_pkg::csb_result_type          decoded;
	logic [1:0]                       cycles;
	logic [csb_pkg::PC_WIDTH-1:0]     branchTarget;
	logic [csb_pkg::PC_WIDTH-1:0]     skipTarget;
	logic                             take;

	assign reqReady = (state_reg == ST_IDLE);
	assign take     = reqValid & reqReady;

	// Offset is signed; sign extension lets branches run backwards
	assign branchTarget = pcIn + {{(csb_pkg::PC_WIDTH-7){req.offset[6]}}, req.offset}
		+ csb_pkg::PC_STEP_NEXT;

	assign skipTarget = pcIn + (nextIsTwoWord ? csb_pkg::PC_STEP_SKIP_TWO
		: csb_pkg::PC_STEP_SKIP_ONE);

	always_comb
	begin
		decoded.statusOut   = statusIn;
		decoded.statusWrite = 1'b0;
		decoded.taken       = 1'b0;
		case (req.op)
			csb_pkg::OP_COMPARE_SKIP_EQUAL: decoded.taken = (req.rdValue == req.rrValue);
			csb_pkg::OP_SKIP_REG_LOW:       decoded.taken = ~req.rrValue[req.bitSel];
			csb_pkg::OP_SKIP_REG_HIGH:      decoded.taken = req.rrValue[req.bitSel];
			csb_pkg::OP_SKIP_IO_LOW:        decoded.taken = ~req.ioValue[req.bitSel];
			csb_pkg::OP_SKIP_IO_HIGH:       decoded.taken = req.ioValue[req.bitSel];
			csb_pkg::OP_BRANCH_FLAG_HIGH:   decoded.taken = statusIn[req.bitSel];
			csb_pkg::OP_BRANCH_FLAG_LOW:    decoded.taken = ~statusIn[req.bitSel];
			csb_pkg::OP_COMPARE_REGISTERS, csb_pkg::OP_COMPARE_IMMEDIATE:
			begin
				decoded.statusOut   = compareFlags(req.rdValue, req.rrValue, 1'b0, 1'b0, statusIn);
				decoded.statusWrite = 1'b1;
			end
			csb_pkg::OP_COMPARE_CARRY:
			begin
				decoded.statusOut   = compareFlags(req.rdValue, req.rrValue,
					statusIn[csb_pkg::FLAG_C], 1'b1, statusIn);
				decoded.statusWrite = 1'b1;
			end
			default: decoded.taken = 1'b0;
		endcase

		if (decoded.taken && isSkipOp(req.op))
		begin
			decoded.pcNext = skipTarget;
			cycles         = nextIsTwoWord ? csb_pkg::CYCLES_SKIP_TWO : csb_pkg::CYCLES_SKIP_ONE;
		end
		else if (decoded.taken)
		begin
			decoded.pcNext = branchTarget;
			cycles         = csb_pkg::CYCLES_BRANCH;
		end
		else
		begin
			decoded.pcNext = pcIn + csb_pkg::PC_STEP_NEXT;
			cycles         = csb_pkg::CYCLES_PLAIN;
		end
	end

	// ==========================================================
	// Cycle sequencing
	always_comb
	begin
		state_next  = state_reg;
		count_next  = count_reg;
		result_next = result_reg;
		done_next   = 1'b0;
		case (state_reg)
			ST_IDLE:
			begin
				if (take)
				begin
					result_next = decoded;
					if (cycles == csb_pkg::CYCLES_PLAIN)
					begin
						done_next = 1'b1;
					end
					else
					begin
						state_next = ST_WAIT;
						count_next = cycles - 2'h1;
					end
				end
			end
			ST_WAIT:
			begin
				count_next = count_reg - 2'h1;
				if (count_reg == 2'h1)
				begin
					done_next  = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg  <= ST_IDLE;
			count_reg  <= 2'h0;
			done_reg   <= 1'b0;
			result_reg <= '0;
		end
		else
		begin
			state_reg  <= state_next;
			count_reg  <= count_next;
			done_reg   <= done_next;
			result_reg <= result_next;
		end
	end

	assign done   = done_reg;
	assign result = result_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence takeSkip;
		take && isSkipOp(req.op) && decoded.taken;
	endsequence

	sequence takeBranch;
		take && !isSkipOp(req.op) && !isCompareOp(req.op) && decoded.taken;
	endsequence

	a_skip_eq_taken: assert property (
		take && req.op == csb_pkg::OP_COMPARE_SKIP_EQUAL && req.rdValue == req.rrValue
		|=> result.taken && !result.statusWrite)
		else $error("equal compare did not skip");

	a_compare_one_cycle: assert property (
		take && isCompareOp(req.op) |=> done && result.statusWrite
		&& result.pcNext == $past(pcIn) + csb_pkg::PC_STEP_NEXT)
		else $error("compare not finished in one cycle");

	a_compare_zero_flag: assert property (
		take && req.op == csb_pkg::OP_COMPARE_REGISTERS && req.rdValue == req.rrValue
		|=> result.statusOut[csb_pkg::FLAG_Z] && !result.statusOut[csb_pkg::FLAG_C])
		else $error("equal compare left zero flag clear");

	a_reg_low_skip: assert property (
		take && req.op == csb_pkg::OP_SKIP_REG_LOW |=> result.taken == !$past(req.rrValue[req.bitSel]))
		else $error("register low skip wrong");

	a_reg_high_skip: assert property (
		take && req.op == csb_pkg::OP_SKIP_REG_HIGH |=> result.taken == $past(req.rrValue[req.bitSel]))
		else $error("register high skip wrong");

	a_io_bit_skip: assert property (
		take && req.op == csb_pkg::OP_SKIP_IO_LOW && !req.ioValue[req.bitSel]
		|=> result.taken && !done)
		else $error("io low skip not taken");

	a_io_high_skip: assert property (
		take && req.op == csb_pkg::OP_SKIP_IO_HIGH && req.ioValue[req.bitSel]
		|=> result.taken && !result.statusWrite)
		else $error("io high skip not taken");

	a_branch_target: assert property (
		takeBranch |=> !done ##1 done && result.pcNext == $past(branchTarget, 2))
		else $error("branch target or timing wrong");

	a_branch_fall: assert property (
		take && req.op == csb_pkg::OP_BRANCH_FLAG_LOW && statusIn[req.bitSel]
		|=> done && !result.taken)
		else $error("clear branch taken on set flag");

	a_skip_two_word: assert property (
		(takeSkip and nextIsTwoWord) |=> !done [*2] ##1 done
		&& result.pcNext == $past(pcIn, 3) + csb_pkg::PC_STEP_SKIP_TWO)
		else $error("two word skip wrong");

	a_skip_one_word: assert property (
		(takeSkip and !nextIsTwoWord) |=> !done ##1 done
		&& result.pcNext == $past(pcIn, 2) + csb_pkg::PC_STEP_SKIP_ONE)
		else $error("one word skip wrong");

endmodule : csb_unit

// ---- tb/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals
	logic                     ref_clk       = 1'h0;
	logic                     rst_b         = 1'h0;
	logic                     reqValid      = 1'h0;
	csb_pkg::csb_request_type req           = '0;
	logic [15:0]              pcIn          = 16'h0000;
	logic [7:0]               statusIn      = 8'h00;
	logic                     nextIsTwoWord = 1'h0;
	logic                     reqReady;
	logic                     done;
	csb_pkg::csb_result_type  result;
	int                       miscompares   = 0;
	int                       compares      = 0;
	logic [31:0]              seed          = 32'h4854;
	logic [31:0]              aux           = 32'h0000;

	always #4 ref_clk = ~ref_clk;

	csb_unit dut_u
	(
		.ref_clk       (ref_clk),
		.rst_b         (rst_b),
		.reqValid      (reqValid),
		.req           (req),
		.pcIn          (pcIn),
		.statusIn      (statusIn),
		.nextIsTwoWord (nextIsTwoWord),
		.reqReady      (reqReady),
		.done          (done),
		.result        (result)
	);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	function automatic csb_pkg::csb_result_type model(input csb_pkg::csb_request_type r,
		input logic [15:0] pc, input logic [7:0] st, input logic tw, output int cyc);
		csb_pkg::csb_result_type e;
		logic [7:0]              a;
		logic [7:0]              b;
		logic [7:0]              d;
		logic                    cop;
		logic                    cond;
		e = '0;
		a = r.rdValue;
		b = r.rrValue;
		cyc = 1;
		cond = 1'h0;
		e.statusOut = st;
		cop = (r.op == csb_pkg::OP_COMPARE_CARRY);
		d = a - b - {7'h0, cop & st[csb_pkg::FLAG_C]};
		case (r.op)
			csb_pkg::OP_COMPARE_SKIP_EQUAL: cond = (a == b);
			csb_pkg::OP_SKIP_REG_LOW:       cond = !b[r.bitSel];
			csb_pkg::OP_SKIP_REG_HIGH:      cond = b[r.bitSel];
			csb_pkg::OP_SKIP_IO_LOW:        cond = !r.ioValue[r.bitSel];
			csb_pkg::OP_SKIP_IO_HIGH:       cond = r.ioValue[r.bitSel];
			csb_pkg::OP_BRANCH_FLAG_HIGH:   cond = st[r.bitSel];
			csb_pkg::OP_BRANCH_FLAG_LOW:    cond = !st[r.bitSel];
			default:
			begin
				// Carry form chains Z so multi-byte compares see all bytes
				e.statusWrite = 1'h1;
				e.statusOut[csb_pkg::FLAG_Z] = (d == 8'h00) && (!cop || st[csb_pkg::FLAG_Z]);
				e.statusOut[csb_pkg::FLAG_N] = d[7];
				e.statusOut[csb_pkg::FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
				e.statusOut[csb_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & d[7]) | (d[7] & ~a[7]);
				e.statusOut[csb_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
			end
		endcase
		e.taken = cond;
		e.pcNext = pc + 16'h0001;
		if (cond && r.op inside {csb_pkg::OP_BRANCH_FLAG_HIGH, csb_pkg::OP_BRANCH_FLAG_LOW})
		begin
			e.pcNext = pc + {{9{r.offset[6]}}, r.offset} + 16'h0001;
			cyc = 2;
		end
		else if (cond)
		begin
			e.pcNext = pc + (tw ? 16'h0003 : 16'h0002);
			cyc = tw ? 3 : 2;
		end
		return e;
	endfunction : model

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask : chk

	task automatic run(input csb_pkg::csb_op_type op, input logic [7:0] rd, input logic [7:0] rr,
		input logic [7:0] io, input logic [2:0] bs, input logic [6:0] off,
		input logic [15:0] pc, input logic [7:0] st, input logic tw);
		csb_pkg::csb_request_type r;
		csb_pkg::csb_result_type  e;
		int                       cyc;
		int                       n;
		r = '{op: op, rdValue: rd, rrValue: rr, ioValue: io, bitSel: bs, offset: off};
		e = model(r, pc, st, tw, cyc);
		@(posedge ref_clk);
		reqValid <= 1'h1;
		req <= r;
		pcIn <= pc;
		statusIn <= st;
		nextIsTwoWord <= tw;
		@(posedge ref_clk);
		reqValid <= 1'h0;
		n = 1;
		#1;
		while (done !== 1'h1 && n < 6)
		begin
			chk("reqReady busy", 16'h0000, {15'h0, reqReady});
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk("cycles", cyc[15:0], n[15:0]);
		chk("pcNext", e.pcNext, result.pcNext);
		chk("taken", {15'h0, e.taken}, {15'h0, result.taken});
		chk("statusWrite", {15'h0, e.statusWrite}, {15'h0, result.statusWrite});
		if (e.statusWrite)
			chk("statusOut", {8'h00, e.statusOut}, {8'h00, result.statusOut});
	endtask : run

	task automatic results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// ==========================================================
	// Sequence
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'h1;
		@(posedge ref_clk);
		#1;
		chk("reqReady idle", 16'h0001, {15'h0, reqReady});
		chk("done idle", 16'h0000, {15'h0, done});
		run(csb_pkg::OP_COMPARE_REGISTERS, 8'h00, 8'h01, 8'h00, 3'h0, 7'h00, 16'h0100, 8'h00, 1'h0);
		run(csb_pkg::OP_COMPARE_REGISTERS, 8'h80, 8'h01, 8'h00, 3'h0, 7'h00, 16'h0200, 8'hff, 1'h0);
		run(csb_pkg::OP_COMPARE_REGISTERS, 8'h5a, 8'h5a, 8'h00, 3'h0, 7'h00, 16'h0280, 8'h01, 1'h0);
		run(csb_pkg::OP_COMPARE_CARRY, 8'h05, 8'h05, 8'h00, 3'h0, 7'h00, 16'h0300, 8'h00, 1'h0);
		run(csb_pkg::OP_COMPARE_CARRY, 8'h06, 8'h05, 8'h00, 3'h0, 7'h00, 16'h0300, 8'h03, 1'h0);
		run(csb_pkg::OP_COMPARE_IMMEDIATE, 8'h10, 8'h10, 8'h00, 3'h0, 7'h00, 16'h0400, 8'h00, 1'h0);
		run(csb_pkg::OP_COMPARE_SKIP_EQUAL, 8'h3c, 8'h3c, 8'h00, 3'h0, 7'h00, 16'hfffe, 8'h00, 1'h1);
		run(csb_pkg::OP_SKIP_IO_HIGH, 8'h00, 8'h00, 8'h80, 3'h7, 7'h00, 16'h0010, 8'h00, 1'h0);
		run(csb_pkg::OP_BRANCH_FLAG_HIGH, 8'h00, 8'h00, 8'h00, 3'h7, 7'h40, 16'h0020, 8'h80, 1'h0);
		run(csb_pkg::OP_BRANCH_FLAG_LOW, 8'h00, 8'h00, 8'h00, 3'h0, 7'h3f, 16'hffc0, 8'hfe, 1'h0);
		// Random mix covers every operation and both outcomes
		for (int i = 0; i < 300; i++)
		begin
			seed = xorshift(seed);
			aux  = xorshift(seed);
			run(csb_pkg::csb_op_type'(4'(seed[7:0] % 8'h0a)), seed[15:8], seed[23:16],
				seed[31:24], seed[10:8], seed[22:16], aux[15:0],
				aux[23:16], seed[3]);
		end
		results();
	end

	// Budget is several times the longest expected run
	initial
	begin
		#60000;
		miscompares++;
		results();
	end

endmodule : tb_top
